// file: tprs_receive_steering.sv
// Notes on behaviour
// - early steer high once valid pair found
// - early steer low on any condition loss
// - steer input high registers detected pair
// - steer input low readies for new pair
// - guard drive from early steer and input
// - register only after full validation period
// - latch 4-bit digit code on registration
// - guard drive high while registered, early high
// - delayed flag rises after short settling delay
// - delayed flag readable as status bit
// - interrupt line low while flag, if enabled
// - output latch loads on flag rising edge
// - data register read returns latched code
// - pause validated by steer input falling
// - short dropouts keep current digit registered
// - digital counting matches standard frequencies
// - one status, two control, two data registers
// - digit code table, D encoded 0000
// - data bus released unless selected for read, phase high
`include "tprs_map.svh"
`default_nettype none

module tprs_digit_encoder (
    input wire logic [1:0] row,
    input wire logic [1:0] col,
    output logic [3:0] code
);

    // ------------------------------------------------------------------
    // row and column to digit code
    // ------------------------------------------------------------------
    always_comb begin
        code = 4'h0;
        if (col == 2'h3) begin
            code = (row == 2'h3) ? 4'h0 : 4'hd + {2'h0, row};
        end else if (row == 2'h3) begin
            unique case (col)
                2'h0: code = 4'hb;
                2'h1: code = 4'ha;
                2'h2: code = 4'hc;
                default: code = 4'h0;
            endcase
        end else begin
            code = 4'({row, 2'h0} - {2'h0, row}) + {2'h0, col} + 4'h1;
        end
    end

endmodule

module tprs_receive_steering #(
    parameter int unsigned CLK_HZ = `TPRS_CLK_HZ,
    parameter int unsigned MATCH_CNT = `TPRS_MATCH_CNT,
    parameter int unsigned CNT_W = `TPRS_CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic low_tone_in,
    input wire logic high_tone_in,
    input wire logic steer_sense_in,
    input wire tprs_pkg::tprs_bus_s bus_in,
    output logic early_steer_out,
    output tprs_pkg::tprs_pin_s guard_time_drive,
    output tprs_pkg::tprs_pin_s interrupt_request_line,
    output logic [3:0] bus_data_lines,
    output logic bus_data_oe
);

    localparam int unsigned SETTLE_CYC_RAW = `TPRS_SETTLE_CYC(CLK_HZ);
    localparam int unsigned SETTLE_CYC =
        (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

    typedef struct packed {
        tprs_pkg::tprs_steer_e mode;
        logic [7:0] settle;
        logic early;
        logic flag;
        logic [3:0] pending;
        logic [3:0] rx_data;
        logic [3:0] tx_data;
        logic [3:0] ctrl_a;
        logic [3:0] ctrl_b;
        logic phase_prev;
        tprs_pkg::tprs_bus_s last;
        logic [3:0] dout;
        logic dout_oe;
        logic guard;
        logic guard_oe;
        logic irq_oe;
    } tprs_top_s;

    tprs_top_s state_reg;
    tprs_top_s state_next;
    tprs_pkg::tprs_group_s group [2];
    logic [1:0] tone_in;
    logic [3:0] digit_code;
    logic [3:0] status;
    logic write_strobe;
    logic read_sel;

    // ------------------------------------------------------------------
    // per-group frequency meters
    // ------------------------------------------------------------------
    assign tone_in = {high_tone_in, low_tone_in};

    localparam int unsigned LOW_F [4] = `TPRS_LOW_HZ;
    localparam int unsigned HIGH_F [4] = `TPRS_HIGH_HZ;

    for (genvar g = 0; g < 2; g++) begin : g_grp
        tprs_freq_meter #(
            .CLK_HZ(CLK_HZ),
            .FREQ_HZ((g == 0) ? LOW_F : HIGH_F),
            .TOL_PCT(`TPRS_TOL_PCT),
            .MATCH_CNT(MATCH_CNT),
            .CNT_W(CNT_W)
        ) u_meter (
            .sys_clk(sys_clk),
            .rst(rst),
            .tone_in(tone_in[g]),
            .group(group[g])
        );
    end

    tprs_digit_encoder u_enc (
        .row(group[0].idx),
        .col(group[1].idx),
        .code(digit_code)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    always_comb begin
        status = 4'h0;
        status[`TPRS_STAT_DSF] = state_reg.flag;
        status[`TPRS_STAT_IRQ] = state_reg.irq_oe;
    end

    assign read_sel = !bus_in.chip_sel_n && bus_in.read_not_write &&
                      bus_in.phase_clk;
    assign write_strobe = state_reg.phase_prev && !bus_in.phase_clk &&
                          !state_reg.last.chip_sel_n &&
                          !state_reg.last.read_not_write;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // signal condition
        state_next.early = group[0].valid && group[1].valid;

        // steering sequence
        unique case (state_reg.mode)
            tprs_pkg::READY: begin
                state_next.flag = 1'b0;
                if (state_reg.early && steer_sense_in) begin
                    state_next.pending = digit_code;
                    state_next.settle = 8'h0;
                    state_next.mode = tprs_pkg::SETTLING;
                end
            end
            tprs_pkg::SETTLING: begin
                if (!steer_sense_in) begin
                    state_next.mode = tprs_pkg::READY;
                end else if (state_reg.settle ==
                             8'(SETTLE_CYC - 1)) begin
                    state_next.flag = 1'b1;
                    state_next.rx_data = state_reg.pending;
                    state_next.mode = tprs_pkg::HELD;
                end else begin
                    state_next.settle = state_reg.settle + 8'h1;
                end
            end
            tprs_pkg::HELD: begin
                // dropouts that keep the input high hold the digit
                if (!steer_sense_in) begin
                    state_next.flag = 1'b0;
                    state_next.mode = tprs_pkg::READY;
                end
            end
            default: begin
                state_next.flag = 1'b0;
                state_next.mode = tprs_pkg::READY;
            end
        endcase

        // guard drive toward the timing network
        state_next.guard_oe = 1'b1;
        if (!state_next.early) begin
            state_next.guard = 1'b0;
        end else if (state_next.mode != tprs_pkg::READY) begin
            state_next.guard = 1'b1;
        end else begin
            state_next.guard = steer_sense_in;
        end

        // interrupt request, open drain
        state_next.irq_oe = state_next.flag &&
                            state_reg.ctrl_a[`TPRS_CTRL_IRQ_EN];

        // bus capture for writes
        state_next.phase_prev = bus_in.phase_clk;
        if (bus_in.phase_clk) begin
            state_next.last = bus_in;
        end
        if (write_strobe) begin
            if (state_reg.last.reg_sel == `TPRS_RS_DATA) begin
                state_next.tx_data = state_reg.last.data;
            end else if (state_reg.ctrl_a[`TPRS_CTRL_SEL_B]) begin
                state_next.ctrl_b = state_reg.last.data;
                state_next.ctrl_a[`TPRS_CTRL_SEL_B] = 1'b0;
            end else begin
                state_next.ctrl_a = state_reg.last.data;
            end
        end

        // read data and bus release
        state_next.dout_oe = read_sel;
        if (!read_sel) begin
            state_next.dout = 4'h0;
        end else if (bus_in.reg_sel == `TPRS_RS_CTRL) begin
            state_next.dout = status;
        end else begin
            state_next.dout = state_next.rx_data;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.mode <= tprs_pkg::READY;
            state_reg.ctrl_a <= `TPRS_CTRL_RESET;
            state_reg.ctrl_b <= `TPRS_CTRL_RESET;
            state_reg.rx_data <= `TPRS_DATA_RESET;
            state_reg.tx_data <= `TPRS_DATA_RESET;
            state_reg.last.chip_sel_n <= 1'b1;
            state_reg.guard_oe <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign early_steer_out = state_reg.early;
    assign guard_time_drive.drive = state_reg.guard;
    assign guard_time_drive.oe = state_reg.guard_oe;
    assign interrupt_request_line.drive = 1'b0;
    assign interrupt_request_line.oe = state_reg.irq_oe;
    assign bus_data_lines = state_reg.dout;
    assign bus_data_oe = state_reg.dout_oe;

endmodule

`default_nettype wire

// file: tprs_map.svh
`ifndef TPRS_MAP_SVH
`define TPRS_MAP_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define TPRS_CLK_HZ 250000000
`define TPRS_SETTLE_NS 40
`define TPRS_SETTLE_CYC(clk_hz) \
    ((`TPRS_SETTLE_NS * ((clk_hz) / 1000000) + 999) / 1000)

// ----------------------------------------------------------------------
// tone decoder
// ----------------------------------------------------------------------
`define TPRS_LOW_HZ '{697, 770, 852, 941}
`define TPRS_HIGH_HZ '{1209, 1336, 1477, 1633}
`define TPRS_TOL_PCT 2
`define TPRS_TIMEOUT_PCT 125
`define TPRS_MATCH_CNT 4
`define TPRS_CNT_W 19

// ----------------------------------------------------------------------
// register select and fields
// ----------------------------------------------------------------------
`define TPRS_RS_DATA 1'h0
`define TPRS_RS_CTRL 1'h1
`define TPRS_CTRL_IRQ_EN 2
`define TPRS_CTRL_SEL_B 3
`define TPRS_STAT_IRQ 0
`define TPRS_STAT_DSF 2
`define TPRS_CTRL_RESET 4'h0
`define TPRS_DATA_RESET 4'h0

`endif

// file: tprs_pkg.sv
`default_nettype none

package tprs_pkg;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [1:0] idx;
    } tprs_group_s;

    typedef enum logic [2:0] {
        READY = 3'h1,
        SETTLING = 3'h2,
        HELD = 3'h4
    } tprs_steer_e;

    typedef struct packed {
        logic chip_sel_n;
        logic read_not_write;
        logic reg_sel;
        logic phase_clk;
        logic [3:0] data;
    } tprs_bus_s;

    typedef struct packed {
        logic drive;
        logic oe;
    } tprs_pin_s;

endpackage

`default_nettype wire

// file: tprs_freq_meter.sv
`include "tprs_map.svh"
`default_nettype none

module tprs_freq_meter #(
    parameter int unsigned CLK_HZ = `TPRS_CLK_HZ,
    parameter int unsigned FREQ_HZ [4] = `TPRS_LOW_HZ,
    parameter int unsigned TOL_PCT = `TPRS_TOL_PCT,
    parameter int unsigned MATCH_CNT = `TPRS_MATCH_CNT,
    parameter int unsigned CNT_W = `TPRS_CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tone_in,
    output tprs_pkg::tprs_group_s group
);

    localparam int unsigned LIMIT =
        (CLK_HZ / FREQ_HZ[0]) / 100 * `TPRS_TIMEOUT_PCT;

    typedef struct packed {
        logic prev;
        logic [CNT_W-1:0] cnt;
        logic [2:0] match;
        tprs_pkg::tprs_group_s grp;
    } tprs_meter_s;

    tprs_meter_s state_reg;
    tprs_meter_s state_next;
    logic [3:0] hit;
    logic [1:0] hit_idx;

    // ------------------------------------------------------------------
    // period windows, one per standard frequency
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_win
        localparam int unsigned NOM = CLK_HZ / FREQ_HZ[i];
        localparam int unsigned LO = NOM / 100 * (100 - TOL_PCT);
        localparam int unsigned HI = NOM / 100 * (100 + TOL_PCT);
        assign hit[i] = state_reg.cnt >= CNT_W'(LO) &&
                        state_reg.cnt <= CNT_W'(HI);
    end

    always_comb begin
        hit_idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 2'(i);
            end
        end
    end

    // ------------------------------------------------------------------
    // period counting between rising edges
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.prev = tone_in;
        if (state_reg.cnt != CNT_W'(LIMIT)) begin
            state_next.cnt = state_reg.cnt + CNT_W'(1);
        end else begin
            state_next.match = 3'h0;
            state_next.grp.valid = 1'b0;
        end
        if (tone_in && !state_reg.prev) begin
            state_next.cnt = CNT_W'(1);
            if (hit == 4'h0) begin
                state_next.match = 3'h0;
                state_next.grp.valid = 1'b0;
            end else if (hit_idx != state_reg.grp.idx) begin
                state_next.grp.idx = hit_idx;
                state_next.match = 3'h1;
                state_next.grp.valid = 1'b0;
            end else if (state_reg.match < 3'(MATCH_CNT)) begin
                state_next.match = state_reg.match + 3'h1;
            end else begin
                state_next.grp.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign group = state_reg.grp;

endmodule

`default_nettype wire

// file: tprs_steer_sva.sv
`include "tprs_map.svh"
`default_nettype none

module tprs_steer_sva #(
    parameter int unsigned CLK_HZ = `TPRS_CLK_HZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic low_tone_in,
    input wire logic high_tone_in,
    input wire logic steer_sense_in,
    input wire tprs_pkg::tprs_bus_s bus_in,
    input wire logic early_steer_out,
    input wire tprs_pkg::tprs_pin_s guard_time_drive,
    input wire tprs_pkg::tprs_pin_s interrupt_request_line,
    input wire logic [3:0] bus_data_lines,
    input wire logic bus_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = `TPRS_SETTLE_CYC(CLK_HZ);

    // --------------------
    // port checks
    // --------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence rd_sel;
        !bus_in.chip_sel_n && bus_in.read_not_write && bus_in.phase_clk;
    endsequence

    sequence held_reg;
        guard_time_drive.drive && early_steer_out;
    endsequence

    AST_GUARD_IDLE: assert property (
        !early_steer_out |-> !guard_time_drive.drive)
        else $error("guard high without early steer");
    AST_GUARD_OE: assert property (guard_time_drive.oe)
        else $error("guard not driven");
    AST_GUARD_SENSE: assert property (
        early_steer_out && $past(steer_sense_in) |-> guard_time_drive.drive)
        else $error("guard ignores steer input");
    AST_GUARD_HOLD: assert property (
        held_reg |=> !early_steer_out || guard_time_drive.drive)
        else $error("guard dropped while early high");
    AST_NO_REG_LOW: assert property (
        !steer_sense_in |=> !guard_time_drive.drive)
        else $error("registered with steer input low");
    AST_FLAG_SETTLE: assert property (
        $rose(interrupt_request_line.oe)
        |-> $past(guard_time_drive.drive, SETTLE))
        else $error("flag without settled registration");
    AST_IRQ_LOW: assert property (!interrupt_request_line.drive)
        else $error("interrupt line driven high");
    AST_IRQ_CLEAR: assert property (
        interrupt_request_line.oe && !steer_sense_in
        |-> ##[1:2] !interrupt_request_line.oe)
        else $error("flag kept after pause");
    AST_BUS_DRIVE: assert property (rd_sel |=> bus_data_oe)
        else $error("read not driven");
    AST_BUS_RELEASE: assert property (not rd_sel |=> !bus_data_oe)
        else $error("bus driven while deselected");
    AST_BUS_ZERO: assert property (
        !bus_data_oe |-> bus_data_lines == 4'h0)
        else $error("data lines not zero while released");
endmodule

`default_nettype wire

// file: tprs_far_model.sv
`default_nettype none

module tprs_far_model #(
    parameter int TGTP = 5000
) (
    input wire logic sys_clk,
    input wire logic early_steer_out,
    input wire tprs_pkg::tprs_pin_s guard_time_drive,
    input wire logic [3:0] bus_data_lines,
    output logic steer_sense_in,
    output tprs_pkg::tprs_bus_s bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int node = 0;

    initial begin
        bus_out = '{1'b1, 1'b1, 1'b0, 1'b0, 4'h5};
    end

    // --------------------
    // steering network and bus master
    // --------------------
    always @(posedge sys_clk) begin
        if (guard_time_drive.oe && guard_time_drive.drive) begin
            node <= 2 * TGTP;
        end else if (early_steer_out) begin
            node <= (node < 2 * TGTP) ? node + 1 : node;
        end else begin
            node <= (node > 0) ? node - 1 : 0;
        end
    end

    assign steer_sense_in = node >= TGTP;

    task automatic rd(input logic rs, output logic [3:0] d);
        @(posedge sys_clk);
        bus_out <= '{1'b0, 1'b1, rs, 1'b1, bus_out.data};
        repeat (2) @(posedge sys_clk);
        d = bus_data_lines;
        bus_out <= '{1'b1, 1'b1, rs, 1'b0, ~bus_out.data};
    endtask

    task automatic wr(input logic rs, input logic [3:0] d);
        @(posedge sys_clk);
        bus_out <= '{1'b0, 1'b0, rs, 1'b1, d};
        @(posedge sys_clk);
        bus_out.phase_clk <= 1'b0;
        @(posedge sys_clk);
        bus_out <= '{1'b1, 1'b1, rs, 1'b0, ~d};
    endtask
endmodule

`default_nettype wire

// file: testbench.sv
`include "tprs_map.svh"
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned CLK = 2500000;
    localparam int unsigned LOW [4] = `TPRS_LOW_HZ;
    localparam int unsigned HIGH [4] = `TPRS_HIGH_HZ;
    localparam logic [63:0] CODES = 64'h0cab_f987_e654_d321;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic steer_sense_in, early_steer_out, bus_data_oe;
    logic [1:0] tone = 2'h0;
    tprs_pkg::tprs_bus_s bus_in;
    tprs_pkg::tprs_pin_s guard_time_drive, interrupt_request_line;
    logic [3:0] bus_data_lines, last_code, d;
    int per [2] = '{0, 0};
    int cnt [2] = '{0, 0};
    int mismatches = 0;
    int n_checks = 0;
    int seed = 32'hece0;
    int r, c;

    always #2 sys_clk = ~sys_clk;

    // --------------------
    // tone sources
    // --------------------
    always @(posedge sys_clk) begin
        for (int g = 0; g < 2; g++) begin
            cnt[g] <= (per[g] == 0 || cnt[g] >= per[g] - 1) ? 0 : cnt[g] + 1;
            tone[g] <= per[g] != 0 && cnt[g] < per[g] / 2;
        end
    end

    tprs_receive_steering #(.CLK_HZ(CLK)) i_tprs_receive_steering (
        .sys_clk(sys_clk),
        .rst(rst),
        .low_tone_in(tone[0]),
        .high_tone_in(tone[1]),
        .steer_sense_in(steer_sense_in),
        .bus_in(bus_in),
        .early_steer_out(early_steer_out),
        .guard_time_drive(guard_time_drive),
        .interrupt_request_line(interrupt_request_line),
        .bus_data_lines(bus_data_lines),
        .bus_data_oe(bus_data_oe)
    );

    tprs_far_model i_tprs_far_model (
        .sys_clk(sys_clk),
        .early_steer_out(early_steer_out),
        .guard_time_drive(guard_time_drive),
        .bus_data_lines(bus_data_lines),
        .steer_sense_in(steer_sense_in),
        .bus_out(bus_in)
    );

    function automatic int period(int unsigned f);
        return (CLK / f / 100) * 100;
    endfunction

    function automatic logic [3:0] code_of(int rr, int cc);
        return CODES[16 * rr + 4 * cc +: 4];
    endfunction

    function automatic logic sig(int k);
        case (k)
            0: return early_steer_out;
            1: return guard_time_drive.drive;
            default: return steer_sense_in;
        endcase
    endfunction

    task automatic conclude;
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wait_lvl(input int k, input logic v, input int lim);
        int i;
        i = 0;
        while (sig(k) !== v && i < lim) begin
            @(posedge sys_clk);
            i++;
        end
        n_checks++;
        if (sig(k) !== v) begin
            mismatches++;
            $display("wrong value level %0d expected %h seen %h", k, v, sig(k));
        end
    endtask

    task automatic digit(input int rr, input int cc, input logic ie);
        logic [3:0] s;
        per[0] <= period(LOW[rr]);
        per[1] <= period(HIGH[cc]);
        wait_lvl(0, 1'b1, 30000);
        wait_lvl(1, 1'b1, 6000);
        i_tprs_far_model.rd(1'b1, s);
        `CHK("status", {2'h1, 1'b0, ie}, s)
        i_tprs_far_model.rd(1'b0, s);
        `CHK("rx code", code_of(rr, cc), s)
        `CHK("irq", ie, interrupt_request_line.oe)
        per[0] <= 0;
        per[1] <= 0;
        wait_lvl(0, 1'b0, 6000);
        `CHK("guard", 1'b0, guard_time_drive.drive)
        wait_lvl(2, 1'b0, 6000);
        i_tprs_far_model.rd(1'b1, s);
        `CHK("status idle", 4'h0, s)
        i_tprs_far_model.rd(1'b0, s);
        `CHK("rx hold", code_of(rr, cc), s)
    endtask

    initial begin
        repeat (95000) @(posedge sys_clk);
        mismatches++;
        conclude;
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        r = $unsigned($random(seed)) % 3;
        c = $unsigned($random(seed)) % 3;
        digit(r, c, 1'b0);
        last_code = code_of(r, c);
        i_tprs_far_model.wr(1'b0, 4'($random(seed)));
        i_tprs_far_model.rd(1'b0, d);
        `CHK("rx after tx write", last_code, d)
        per[0] <= period(LOW[c]);
        per[1] <= period(HIGH[r]);
        wait_lvl(0, 1'b1, 30000);
        per[0] <= period(LOW[c]) / 2;
        wait_lvl(0, 1'b0, 4500);
        per[0] <= 0;
        per[1] <= 0;
        i_tprs_far_model.rd(1'b1, d);
        `CHK("status short", 4'h0, d)
        i_tprs_far_model.rd(1'b0, d);
        `CHK("rx short", last_code, d)
        i_tprs_far_model.wr(1'b1, 4'h4);
        digit(3, 3, 1'b1);
        conclude;
    end
endmodule

bind tprs_receive_steering tprs_steer_sva #(.CLK_HZ(CLK_HZ)) i_tprs_steer_sva (
    .sys_clk(sys_clk),
    .rst(rst),
    .low_tone_in(low_tone_in),
    .high_tone_in(high_tone_in),
    .steer_sense_in(steer_sense_in),
    .bus_in(bus_in),
    .early_steer_out(early_steer_out),
    .guard_time_drive(guard_time_drive),
    .interrupt_request_line(interrupt_request_line),
    .bus_data_lines(bus_data_lines),
    .bus_data_oe(bus_data_oe)
);

`default_nettype wire
